//--- dra_pkg.sv
// Package: constants and carriers for the display RAM access command block
package dra_pkg;

  // ************************************************************
  // Instruction codes
  // ************************************************************
  localparam logic [7:0] CODE_CURSOR_LOW = 8'h0a;
  localparam logic [7:0] CODE_CURSOR_HIGH = 8'h0b;
  localparam logic [7:0] CODE_WRITE_DATA = 8'h0c;
  localparam logic [7:0] CODE_READ_DATA = 8'h0d;
  localparam logic [7:0] CODE_BIT_CLEAR = 8'h0e;
  localparam logic [7:0] CODE_BIT_SET = 8'h0f;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int BUSY_BIT_POS = 7;
  localparam int BIT_NUM_MSB = 2;
  localparam logic [7:0] INSTR_RESET = 8'h00;
  localparam logic [15:0] CURSOR_RESET = 16'h0000;
  localparam logic [7:0] READ_REG_RESET = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 25;
  localparam int DATA_TIME_US = 6;
  localparam int BIT_TIME_US = 36;
  localparam int DATA_CYCLES = DATA_TIME_US * CLK_MHZ;
  localparam int BIT_CYCLES = BIT_TIME_US * CLK_MHZ;
  localparam int BUSY_CNT_W = 10;

  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;

  // Host bus access as seen on the pins
  typedef struct packed {
    logic strobe;
    logic registerSelect;
    logic readNotWrite;
    logic [7:0] data;
  } dra_host_req_t;

  // Memory port request
  typedef struct packed {
    logic enable;
    logic write;
    logic [15:0] address;
    logic [7:0] data;
  } dra_mem_req_t;

  typedef enum logic [1:0] {
    OP_WRITE,
    OP_READ,
    OP_CLEAR,
    OP_SET
  } dra_op_t;

endpackage : dra_pkg

//--- dra_fifo.sv
// Module: parameterised valid/ready FIFO for host write data
`timescale 1ns/1ps
module dra_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic doPush;
  logic doPop;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  assign outData = store[rdPtr];

  always_ff @(posedge clk) begin
    if (doPush) begin
      store[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end

  AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk) disable iff (rst)
    count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : dra_fifo

//--- dra_busy_timer.sv
// Module: busy flag timer loaded with an execution time in cycles
`timescale 1ns/1ps
module dra_busy_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [dra_pkg::BUSY_CNT_W-1:0] cycles,
  output logic busy,
  output logic done
);
  logic [dra_pkg::BUSY_CNT_W-1:0] remaining;

  assign busy = (remaining != '0);
  assign done = (remaining == dra_pkg::BUSY_CNT_W'(1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remaining <= '0;
    end else if (start) begin
      remaining <= cycles;
    end else if (busy) begin
      remaining <= remaining - 1'b1;
    end
  end
endmodule : dra_busy_timer

//--- dra_command_block.sv
// Module: host command interpreter for display RAM access
// Behaviour
// - Code 0x0C then data byte writes RAM
// - Cursor increments after each data write
// - Busy 6 us data, 36 us bit ops
// - Code 0x0D then data reads read RAM
// - Read drives holding reg, refills, increments
// - Codes 0x0E/0x0F clear or set one bit
// - Parameter low three bits give bit index
// - Cursor increments after bit operation
// - Status read returns busy on msb
// - Busy high while executing, low after
// - No queued byte executed while busy; codes load anytime
// - Instruction code write leaves busy unchanged
// - Busy readable regardless of instruction
// - Cursor is 16-bit counter, low wrap carries
// - Codes 0x0A/0x0B load cursor bytes
`timescale 1ns/1ps
module dra_command_block (
  input wire logic clk,
  input wire logic rst,
  input wire dra_pkg::dra_host_req_t hostReq,
  output logic [7:0] hostDataOut,
  output logic hostDataOutEnable_n,
  output logic busyFlag,
  output logic dataInReady,
  output dra_pkg::dra_mem_req_t memReq,
  input wire logic [7:0] memReadData,
  output logic [15:0] cursorAddress
);

  // ************************************************************
  // Declarations
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_MODIFY
  } dra_state_t;

  dra_state_t state;
  logic [7:0] instruction;
  logic [7:0] readHolding;
  logic [7:0] bitParam;
  dra_pkg::dra_op_t pendingOp;
  logic busy;
  logic timerDone;
  logic timerStart;
  logic [dra_pkg::BUSY_CNT_W-1:0] timerCycles;
  logic cursorStep;
  logic loadLow;
  logic loadHigh;
  logic dataWrite;
  logic dataRead;
  logic fifoValid;
  logic fifoPop;
  logic [7:0] fifoData;
  logic refill;
  logic [15:0] next_cursor;
  logic bitTiming;
  logic [dra_pkg::BUSY_CNT_W-1:0] bitBusyCount;

  function automatic logic [7:0] bitMask(input logic [7:0] param);
    bitMask = 8'h01 << param[dra_pkg::BIT_NUM_MSB:0];
  endfunction : bitMask

  // ************************************************************
  // Host strobe decode
  // ************************************************************
  // Data writes queue in the FIFO; the FIFO only drains when not busy
  assign dataWrite = hostReq.strobe && !hostReq.registerSelect && !hostReq.readNotWrite;
  assign dataRead = hostReq.strobe && !hostReq.registerSelect && hostReq.readNotWrite
    && (instruction == dra_pkg::CODE_READ_DATA) && !busy;

  dra_fifo #(
    .WIDTH(dra_pkg::FIFO_WIDTH),
    .DEPTH(dra_pkg::FIFO_DEPTH)
  ) uDataFifo (
    .clk(clk),
    .rst(rst),
    .inValid(dataWrite),
    .inReady(dataInReady),
    .inData(hostReq.data),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  // Busy gates execution of every queued byte
  assign fifoPop = fifoValid && !busy && (state == ST_IDLE);
  assign loadLow = fifoPop && (instruction == dra_pkg::CODE_CURSOR_LOW);
  assign loadHigh = fifoPop && (instruction == dra_pkg::CODE_CURSOR_HIGH);

  // ************************************************************
  // Instruction register
  // ************************************************************
  // Code writes never start the timer, so busy stays as it is
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instruction <= dra_pkg::INSTR_RESET;
    end else if (hostReq.strobe && hostReq.registerSelect && !hostReq.readNotWrite) begin
      instruction <= hostReq.data;
    end
  end

  // ************************************************************
  // Execution sequencer
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      bitParam <= 8'h00;
      pendingOp <= dra_pkg::OP_WRITE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (fifoPop && (instruction == dra_pkg::CODE_BIT_CLEAR)) begin
            bitParam <= fifoData;
            pendingOp <= dra_pkg::OP_CLEAR;
            state <= ST_FETCH;
          end else if (fifoPop && (instruction == dra_pkg::CODE_BIT_SET)) begin
            bitParam <= fifoData;
            pendingOp <= dra_pkg::OP_SET;
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state <= ST_MODIFY;
        end
        ST_MODIFY: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Memory port
  // ************************************************************
  // Read refill happens in the cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refill <= 1'b0;
    end else begin
      refill <= dataRead;
    end
  end

  always_comb begin
    memReq = '0;
    if (fifoPop && (instruction == dra_pkg::CODE_WRITE_DATA)) begin
      memReq.enable = 1'b1;
      memReq.write = 1'b1;
      memReq.address = cursorAddress;
      memReq.data = fifoData;
    end else if (dataRead || (state == ST_FETCH)) begin
      memReq.enable = 1'b1;
      memReq.address = cursorAddress;
    end else if (state == ST_MODIFY) begin
      memReq.enable = 1'b1;
      memReq.write = 1'b1;
      memReq.address = cursorAddress;
      if (pendingOp == dra_pkg::OP_SET) begin
        memReq.data = memReadData | bitMask(bitParam);
      end else begin
        memReq.data = memReadData & ~bitMask(bitParam);
      end
    end
  end

  // Output holding register, loaded after it was put on the bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readHolding <= dra_pkg::READ_REG_RESET;
    end else if (refill) begin
      readHolding <= memReadData;
    end
  end

  // ************************************************************
  // Cursor counter
  // ************************************************************
  assign cursorStep = (fifoPop && (instruction == dra_pkg::CODE_WRITE_DATA))
    || refill
    || (state == ST_MODIFY);

  // Low-byte load carries when bit 7 falls, so host must reload high byte
  always_comb begin
    next_cursor = cursorAddress;
    if (loadLow) begin
      next_cursor[7:0] = fifoData;
      if (cursorAddress[7] && !fifoData[7]) begin
        next_cursor[15:8] = cursorAddress[15:8] + 8'h01;
      end
    end else if (loadHigh) begin
      next_cursor[15:8] = fifoData;
    end else if (cursorStep) begin
      next_cursor = cursorAddress + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cursorAddress <= dra_pkg::CURSOR_RESET;
    end else begin
      cursorAddress <= next_cursor;
    end
  end

  // ************************************************************
  // Busy flag
  // ************************************************************
  always_comb begin
    timerStart = 1'b0;
    timerCycles = '0;
    if (fifoPop && ((instruction == dra_pkg::CODE_BIT_CLEAR)
        || (instruction == dra_pkg::CODE_BIT_SET))) begin
      timerStart = 1'b1;
      timerCycles = dra_pkg::BUSY_CNT_W'(dra_pkg::BIT_CYCLES);
    end else if (fifoPop || dataRead) begin
      timerStart = 1'b1;
      timerCycles = dra_pkg::BUSY_CNT_W'(dra_pkg::DATA_CYCLES);
    end
  end

  dra_busy_timer uBusyTimer (
    .clk(clk),
    .rst(rst),
    .start(timerStart),
    .cycles(timerCycles),
    .busy(busy),
    .done(timerDone)
  );

  assign busyFlag = busy;

  // ************************************************************
  // Host read data
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hostDataOut <= 8'h00;
    end else if (hostReq.strobe && hostReq.readNotWrite) begin
      if (hostReq.registerSelect) begin
        hostDataOut <= {busy, 7'h00};
      end else if (dataRead) begin
        hostDataOut <= readHolding;
      end
    end
  end

  assign hostDataOutEnable_n = !(hostReq.strobe && hostReq.readNotWrite);

  // ************************************************************
  // Checks
  // ************************************************************
  AST_WRITE_INCREMENTS: assert property (@(posedge clk) disable iff (rst)
    (fifoPop && instruction == dra_pkg::CODE_WRITE_DATA)
    |=> cursorAddress == $past(cursorAddress) + 16'h0001)
    else $error("cursor did not step after data write");

  AST_DATA_BUSY_TIME: assert property (@(posedge clk) disable iff (rst)
    (timerStart && timerCycles == dra_pkg::BUSY_CNT_W'(dra_pkg::DATA_CYCLES))
    |=> busy [*8] ##143 !busy)
    else $error("data busy time wrong");

  // Bit op busy is too long for a plain delay, so count it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitTiming <= 1'b0;
      bitBusyCount <= '0;
    end else if (timerStart && timerCycles == dra_pkg::BUSY_CNT_W'(dra_pkg::BIT_CYCLES)) begin
      bitTiming <= 1'b1;
      bitBusyCount <= '0;
    end else if (bitTiming && busy) begin
      bitBusyCount <= bitBusyCount + 1'b1;
    end else begin
      bitTiming <= 1'b0;
    end
  end

  AST_BIT_BUSY_LONG: assert property (@(posedge clk) disable iff (rst)
    (bitTiming && !busy)
    |-> bitBusyCount == dra_pkg::BUSY_CNT_W'(dra_pkg::BIT_CYCLES))
    else $error("bit op busy time wrong");

  AST_READ_REFILL: assert property (@(posedge clk) disable iff (rst)
    dataRead |=> refill ##1 (readHolding == $past(memReadData)
      && cursorAddress == $past(cursorAddress, 2) + 16'h0001))
    else $error("read holding not refilled");

  AST_BIT_OP_RESULT: assert property (@(posedge clk) disable iff (rst)
    (state == ST_MODIFY && pendingOp == dra_pkg::OP_SET)
    |-> memReq.write && memReq.data[bitParam[2:0]])
    else $error("bit set did not set bit");

  AST_BIT_OP_STEP: assert property (@(posedge clk) disable iff (rst)
    state == ST_MODIFY |=> cursorAddress == $past(cursorAddress) + 16'h0001)
    else $error("cursor did not step after bit op");

  AST_STATUS_READ: assert property (@(posedge clk) disable iff (rst)
    (hostReq.strobe && hostReq.readNotWrite && hostReq.registerSelect)
    |=> hostDataOut == {$past(busy), 7'h00})
    else $error("status read wrong");

  AST_NO_EXEC_BUSY: assert property (@(posedge clk) disable iff (rst)
    busy |-> !fifoPop)
    else $error("executed while busy");

  AST_CODE_KEEPS_BUSY: assert property (@(posedge clk) disable iff (rst)
    (hostReq.strobe && hostReq.registerSelect && !hostReq.readNotWrite && !busy
      && !fifoValid && !dataRead && state == ST_IDLE) |=> !busy)
    else $error("code write changed busy");

  AST_LOW_CARRY: assert property (@(posedge clk) disable iff (rst)
    (loadLow && cursorAddress[7] && !fifoData[7])
    |=> cursorAddress[15:8] == $past(cursorAddress[15:8]) + 8'h01)
    else $error("low load carry missing");

endmodule : dra_command_block

//--- dra_ram_model.sv
// External display RAM model answering the memory port
`timescale 1ns/1ps
module dra_ram_model (
  input wire logic clk,
  input wire dra_pkg::dra_mem_req_t memReq,
  output logic [7:0] memReadData
);
  logic [7:0] mem [0:65535];
  logic [15:0] holdAddr = 16'h0000;
  logic holdValid = 1'b0;
  logic [7:0] junk = 8'h5a;
  // ************************************************************
  // Store and one-cycle read hold
  // ************************************************************
  always @(posedge clk) begin
    junk <= ~junk + 8'h01;
    holdValid <= memReq.enable & ~memReq.write;
    holdAddr <= memReq.address;
    if (memReq.enable && memReq.write) mem[memReq.address] <= memReq.data;
  end
  // Outside a read window the lines churn, so a stale value never passes
  always_comb begin
    if (memReq.enable && !memReq.write) memReadData = mem[memReq.address];
    else if (holdValid) memReadData = mem[holdAddr];
    else memReadData = junk;
  end
endmodule : dra_ram_model

//--- dra_command_block_tb_top.sv
// Self-checking testbench for the display RAM access command block
`timescale 1ns/1ps
module dra_command_block_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  dra_pkg::dra_host_req_t hostReq = '0;
  logic [7:0] hostDataOut;
  logic hostDataOutEnable_n;
  logic busyFlag;
  logic dataInReady;
  dra_pkg::dra_mem_req_t memReq;
  logic [7:0] memReadData;
  logic [15:0] cursorAddress;
  logic rdSeen = 1'b0;
  logic [7:0] expQ[$];
  logic [7:0] expV;
  logic [7:0] accQ[$];
  int err_total = 0;
  int compares = 0;

  dra_command_block dut_u (
    .clk(clk),
    .rst(rst),
    .hostReq(hostReq),
    .hostDataOut(hostDataOut),
    .hostDataOutEnable_n(hostDataOutEnable_n),
    .busyFlag(busyFlag),
    .dataInReady(dataInReady),
    .memReq(memReq),
    .memReadData(memReadData),
    .cursorAddress(cursorAddress)
  );
  dra_ram_model ram_u (
    .clk(clk),
    .memReq(memReq),
    .memReadData(memReadData)
  );

  initial begin
    forever #20 clk = ~clk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic test_done();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // One strobe per access; strobe drops at the taking edge
  task automatic hostAccess(input logic rs, input logic rnw, input logic [7:0] d, output logic rdy);
    @(posedge clk);
    hostReq <= '{strobe: 1'b1, registerSelect: rs, readNotWrite: rnw, data: d};
    @(negedge clk);
    rdy = dataInReady;
    if (rnw) check("hostDataOutEnable_n", 16'h0000, {15'h0, hostDataOutEnable_n});
    @(posedge clk);
    hostReq.strobe <= 1'b0;
  endtask : hostAccess

  task automatic instr(input logic [7:0] code);
    logic r;
    hostAccess(1'b1, 1'b0, code, r);
  endtask : instr

  task automatic wdata(input logic [7:0] d);
    logic r;
    hostAccess(1'b0, 1'b0, d, r);
  endtask : wdata

  task automatic rd(input logic rs, input logic [7:0] exp);
    logic r;
    expQ.push_back(exp);
    hostAccess(rs, 1'b1, 8'h00, r);
  endtask : rd

  // Counts busy cycles of one execution; bounded
  task automatic waitIdle(output int n);
    int k;
    n = 0;
    for (k = 0; k < 3000 && (n == 0 || busyFlag === 1'b1); k++) begin
      @(negedge clk);
      if (busyFlag === 1'b1) n++;
    end
    if (k == 3000) begin
      err_total++;
      $display("wrong value busyFlag expected 0 seen 1");
      test_done();
    end
  endtask : waitIdle

  task automatic loadByte(input logic [7:0] code, input logic [7:0] d);
    int n;
    instr(code);
    wdata(d);
    waitIdle(n);
  endtask : loadByte

  // ************************************************************
  // Read result monitor
  // ************************************************************
  always @(posedge clk) rdSeen <= hostReq.strobe & hostReq.readNotWrite;
  always @(negedge clk) begin
    if (rdSeen) begin
      if (expQ.size() == 0) begin
        err_total++;
        $display("wrong value hostDataOut expected none seen %h", hostDataOut);
      end else begin
        expV = expQ.pop_front();
        check("hostDataOut", {8'h00, expV}, {8'h00, hostDataOut});
      end
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    int n;
    int k;
    logic r;
    logic [7:0] v;
    logic [7:0] e;
    logic [15:0] a;
    n = $urandom(8);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(1'b1, 8'h00);
    check("cursorAddress", dra_pkg::CURSOR_RESET, cursorAddress);
    loadByte(dra_pkg::CODE_CURSOR_LOW, 8'hff);
    loadByte(dra_pkg::CODE_CURSOR_HIGH, 8'h12);
    check("cursorAddress", 16'h12ff, cursorAddress);
    instr(dra_pkg::CODE_WRITE_DATA);
    wdata(8'ha5);
    waitIdle(n);
    check("busyCycles", dra_pkg::DATA_CYCLES, n);
    check("ram", 16'h00a5, {8'h00, ram_u.mem[16'h12ff]});
    check("cursorAddress", 16'h1300, cursorAddress);
    loadByte(dra_pkg::CODE_CURSOR_LOW, 8'h80);
    check("cursorAddress", 16'h1380, cursorAddress);
    loadByte(dra_pkg::CODE_CURSOR_LOW, 8'h00);
    check("cursorAddress", 16'h1400, cursorAddress);
    loadByte(dra_pkg::CODE_CURSOR_HIGH, 8'h12);
    check("cursorAddress", 16'h1200, cursorAddress);
    // Data read path, dummy read first
    loadByte(dra_pkg::CODE_CURSOR_LOW, 8'hff);
    loadByte(dra_pkg::CODE_CURSOR_HIGH, 8'h12);
    ram_u.mem[16'h1300] = 8'h3c;
    instr(dra_pkg::CODE_READ_DATA);
    rd(1'b0, dra_pkg::READ_REG_RESET);
    waitIdle(n);
    rd(1'b0, 8'ha5);
    rd(1'b0, 8'ha5);
    waitIdle(n);
    check("cursorAddress", 16'h1301, cursorAddress);
    // Every bit number, both bit codes
    a = cursorAddress;
    for (k = 0; k < 8; k++) begin
      v = 8'($urandom());
      ram_u.mem[a + 16'(k)] = v;
      e = k[0] ? (v | (8'h01 << k)) : (v & ~(8'h01 << k));
      instr(k[0] ? dra_pkg::CODE_BIT_SET : dra_pkg::CODE_BIT_CLEAR);
      wdata({5'h00, 3'(k)});
      waitIdle(n);
      check("busyCycles", dra_pkg::BIT_CYCLES, n);
      check("ram", {8'h00, e}, {8'h00, ram_u.mem[a + 16'(k)]});
      check("cursorAddress", a + 16'(k) + 16'h0001, cursorAddress);
    end
    rd(1'b1, 8'h00);
    // Fill the write buffer until it refuses, then drain
    instr(dra_pkg::CODE_WRITE_DATA);
    a = cursorAddress;
    for (k = 0; k < 20; k++) begin
      v = 8'($urandom());
      hostAccess(1'b0, 1'b0, v, r);
      if (r === 1'b1) accQ.push_back(v);
    end
    check("accepted", 16'(dra_pkg::FIFO_DEPTH + 1), 16'(accQ.size()));
    rd(1'b1, 8'h80);
    instr(dra_pkg::CODE_WRITE_DATA);
    @(negedge clk);
    check("busyFlag", 16'h0001, {15'h0, busyFlag});
    for (k = 0; k < 4000 && cursorAddress !== a + 16'(accQ.size()); k++) @(negedge clk);
    waitIdle(n);
    for (k = 0; k < accQ.size(); k++) begin
      check("ram", {8'h00, accQ[k]}, {8'h00, ram_u.mem[a + 16'(k)]});
    end
    rd(1'b0, 8'h80);
    @(negedge clk);
    check("cursorAddress", a + 16'(accQ.size()), cursorAddress);
    test_done();
  end
endmodule : dra_command_block_tb_top
